// [hw/dpt_cfg.v]
// Purpose: deviation register, post-transmit state choice, modulator steering
// Assumes: avalon-mm slave, one 8-bit register per aligned 32-bit word
// Notes: tx_start and pkt_done are same-clock pulses from the packet engine
//
// Local design decision: register access over Avalon-MM.
`default_nettype none
`include "dpt_consts.vh"
module dpt_cfg #(
  parameter XOSC_HZ = 26000000
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire tx_start,
  input wire pkt_done,
  input wire sym_start,
  input wire eighth_tick,
  input wire data_bit,
  output reg [1:0] radio_state_ff,
  output reg preamble_restart_ff,
  output reg fsk_en_ff,
  output reg [3:0] dev_mant_ff,
  output reg [2:0] dev_exp_ff,
  output reg [31:0] dev_step_ff,
  output wire msk_phase_active,
  output wire msk_phase_neg,
  output reg ask_en_ff
);
  ////////////////////////////////////////////////////////////////////////////
  // register file
  reg [2:0] dev_e_ff;
  reg [2:0] dev_m_ff;
  reg [1:0] post_tx_state_sel_ff;
  reg [2:0] modulation_select_ff;
  reg rd_pend_ff;
  reg [2:0] act_mod_ff;
  reg [1:0] act_txoff_ff;
  reg msk_en_ff;
  wire wr_lane0;
  wire [7:0] wb;
  // reads take one extra cycle so readdata comes from a flop
  assign avs_waitrequest = avs_read && !rd_pend_ff;
  assign wr_lane0 = avs_write && avs_byteenable[0];
  assign wb = avs_writedata[7:0];
  function [1:0] dpt_mod_class;
    input [2:0] code;
    begin
      case (code)
        `DPT_MOD_FSK2: dpt_mod_class = 2'h1;
        `DPT_MOD_GFSK: dpt_mod_class = 2'h1;
        `DPT_MOD_ASK: dpt_mod_class = 2'h2;
        `DPT_MOD_MSK: dpt_mod_class = 2'h3;
        default: dpt_mod_class = 2'h0;
      endcase
    end
  endfunction
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      dev_e_ff <= `DPT_DEV_E_RST;
      dev_m_ff <= `DPT_DEV_M_RST;
      post_tx_state_sel_ff <= `DPT_TXOFF_RST;
      modulation_select_ff <= `DPT_MOD_RST;
      rd_pend_ff <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      rd_pend_ff <= avs_read && !rd_pend_ff;
      if (wr_lane0)
      begin
        case (avs_address)
          `DPT_IDX_DEV:
          begin
            dev_e_ff <= wb[6:4]; // bits 7 and 3 dropped
            dev_m_ff <= wb[2:0];
          end
          `DPT_IDX_SM1: post_tx_state_sel_ff <= wb[1:0];
          `DPT_IDX_MOD: modulation_select_ff <= wb[6:4];
          default: ;
        endcase
      end
      if (avs_read && !rd_pend_ff)
      begin
        case (avs_address)
          `DPT_IDX_DEV: avs_readdata <= {24'h0, 1'b0, dev_e_ff, 1'b0, dev_m_ff};
          `DPT_IDX_SM1: avs_readdata <= {24'h0, 2'h0, `DPT_SM1_RSVD, post_tx_state_sel_ff};
          `DPT_IDX_MOD: avs_readdata <= {24'h0, 1'b0, modulation_select_ff, 4'h0};
          `DPT_IDX_STS: avs_readdata <= {24'h0, 1'b0, act_mod_ff, 2'h0, radio_state_ff};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // settings latched at transmit start; the msk ramp length still follows the live dev_m_ff, so a mid-flight write changes it
  wire [1:0] cls;
  assign cls = dpt_mod_class(modulation_select_ff);
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      act_mod_ff <= `DPT_MOD_RST;
      act_txoff_ff <= `DPT_TXOFF_RST;
      fsk_en_ff <= 1'b0;
      msk_en_ff <= 1'b0;
      ask_en_ff <= 1'b0;
      dev_mant_ff <= `DPT_MANT_BASE;
      dev_exp_ff <= 3'h0;
      dev_step_ff <= 32'h0;
    end
    else if (tx_start)
    begin
      act_mod_ff <= modulation_select_ff;
      act_txoff_ff <= post_tx_state_sel_ff;
      fsk_en_ff <= (cls == 2'h1);
      msk_en_ff <= (cls == 2'h3);
      ask_en_ff <= (cls == 2'h2);
      if (cls == 2'h1)
      begin
        dev_mant_ff <= {1'b1, dev_m_ff};
        dev_exp_ff <= dev_e_ff;
        // step in units of fxosc/2^17: (8+m)<<e
        // shift in full width: (8+7)<<7 needs 11 bits, an 8-bit shift would wrap
        dev_step_ff <= {28'h0, `DPT_MANT_BASE | {1'b0, dev_m_ff}} << dev_e_ff;
      end
      else
      begin
        // ask/ook and msk leave the fsk deviation at zero
        dev_mant_ff <= 4'h0;
        dev_exp_ff <= 3'h0;
        dev_step_ff <= 32'h0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // post-transmit state choice
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      radio_state_ff <= `DPT_ST_IDLE;
      preamble_restart_ff <= 1'b0;
    end
    else
    begin
      preamble_restart_ff <= 1'b0;
      if (tx_start)
        radio_state_ff <= `DPT_ST_TX;
      else if (pkt_done && radio_state_ff == `DPT_ST_TX)
      begin
        case (act_txoff_ff)
          `DPT_TXOFF_IDLE: radio_state_ff <= `DPT_ST_IDLE;
          `DPT_TXOFF_FSTX: radio_state_ff <= `DPT_ST_FSON;
          `DPT_TXOFF_STAY: preamble_restart_ff <= 1'b1;
          // code 11 unsupported; fall back to idle
          default: radio_state_ff <= `DPT_ST_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // msk phase stepping; mantissa here is a fraction, not a deviation
  dpt_phase_step u_phase (
    .mclk(mclk),
    .resetn(resetn),
    .enable(msk_en_ff),
    .sym_start(sym_start),
    .data_bit(data_bit),
    .eighth_tick(eighth_tick),
    .frac_m(dev_m_ff),
    .phase_active_ff(msk_phase_active),
    .phase_dir_neg_ff(msk_phase_neg)
  );
endmodule // dpt_cfg
`default_nettype wire

// [pkg/dpt_consts.vh]
// Purpose: constants for the deviation and post-transmit configuration block
// Assumes: 8-bit registers, one per 32-bit word on the register bus
// Notes: printed offsets are register indices; byte address is four times the index
`ifndef DPT_CONSTS_VH
`define DPT_CONSTS_VH
`define DPT_IDX_DEV 8'h15
`define DPT_IDX_SM1 8'h17
`define DPT_IDX_MOD 8'h12
`define DPT_IDX_CTL 8'h30
`define DPT_IDX_STS 8'h31
`define DPT_DEV_E_RST 3'h4
`define DPT_DEV_M_RST 3'h7
`define DPT_SM1_RSVD 4'hc
`define DPT_TXOFF_RST 2'h0
`define DPT_MOD_RST 3'h0
`define DPT_MOD_FSK2 3'h0
`define DPT_MOD_GFSK 3'h1
`define DPT_MOD_ASK 3'h3
`define DPT_MOD_MSK 3'h7
`define DPT_TXOFF_IDLE 2'h0
`define DPT_TXOFF_FSTX 2'h1
`define DPT_TXOFF_STAY 2'h2
`define DPT_ST_IDLE 2'h0
`define DPT_ST_FSON 2'h1
`define DPT_ST_TX 2'h2
`define DPT_DEV_SHIFT 17
`define DPT_MANT_BASE 4'h8
`endif

// [hw/dpt_phase_step.v]
// Purpose: per-symbol phase step for msk: rotation direction and ramp length
// Assumes: symbol strobe and data bit come from logic on mclk
// Notes: ramp length in eighths of a symbol, counted with a sub-symbol enable
`default_nettype none
module dpt_phase_step (
  input wire mclk,
  input wire resetn,
  input wire enable,
  input wire sym_start,
  input wire data_bit,
  input wire eighth_tick,
  input wire [2:0] frac_m,
  output reg phase_active_ff,
  output reg phase_dir_neg_ff
);
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (!enable)
      nxt_cnt = 4'h0;
    else if (sym_start)
      nxt_cnt = {1'b0, frac_m} + 4'h1;
    else if (eighth_tick && cnt_ff != 4'h0)
      nxt_cnt = cnt_ff - 4'h1;
  end
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      cnt_ff <= 4'h0;
      phase_active_ff <= 1'b0;
      phase_dir_neg_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      phase_active_ff <= (nxt_cnt != 4'h0);
      if (enable && sym_start)
        phase_dir_neg_ff <= data_bit;
    end
  end
endmodule // dpt_phase_step
`default_nettype wire

// [tb/dpt_cfg_chk.sv]
// Purpose: port assertions for dpt_cfg
// Assumes: one clock, sync active-low reset
// Notes: bound to every dpt_cfg instance
`default_nettype none
`include "dpt_consts.vh"
////////////////////////////////////////////////////////////////////////
module dpt_cfg_chk (
  input wire mclk,
  input wire resetn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  input wire tx_start,
  input wire pkt_done,
  input wire data_bit,
  input wire [1:0] radio_state_ff,
  input wire preamble_restart_ff,
  input wire fsk_en_ff,
  input wire [3:0] dev_mant_ff,
  input wire [2:0] dev_exp_ff,
  input wire [31:0] dev_step_ff,
  input wire msk_phase_active,
  input wire msk_phase_neg,
  input wire ask_en_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_WR_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  AST_RD_ONEWAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait not one cycle");
  AST_RD_HIGH_ZERO: assert property ($past(avs_read) && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_FSK_MANT: assert property (fsk_en_ff |-> dev_mant_ff[3] && !ask_en_ff)
    else $error("mantissa lacks leading one");
  AST_FSK_STEP: assert property (fsk_en_ff |-> dev_step_ff == ({28'h0, dev_mant_ff} << dev_exp_ff))
    else $error("deviation step wrong");
  AST_ASK_NODEV: assert property (ask_en_ff |-> dev_step_ff == 32'h0)
    else $error("deviation used in ask");
  AST_TX_START: assert property (tx_start |=> radio_state_ff == `DPT_ST_TX)
    else $error("no transmit after start");
  AST_POST_TX: assert property (pkt_done && radio_state_ff == `DPT_ST_TX |=> preamble_restart_ff || radio_state_ff != `DPT_ST_TX)
    else $error("stuck in transmit");
  AST_RESTART: assert property (preamble_restart_ff |-> radio_state_ff == `DPT_ST_TX ##1 !preamble_restart_ff)
    else $error("bad preamble restart");
  AST_MSK_DIR: assert property ($rose(msk_phase_active) |-> msk_phase_neg == $past(data_bit))
    else $error("phase direction wrong");
endmodule // dpt_cfg_chk
bind dpt_cfg dpt_cfg_chk u_chk (.mclk, .resetn, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdata, .tx_start, .pkt_done, .data_bit, .radio_state_ff, .preamble_restart_ff,
  .fsk_en_ff, .dev_mant_ff, .dev_exp_ff, .dev_step_ff, .msk_phase_active, .msk_phase_neg,
  .ask_en_ff);
`default_nettype wire

// [tb/dpt_cfg_test.sv]
// Purpose: self-checking bench for dpt_cfg
// Assumes: avalon-mm master, one clock
// Notes: byteenable tied to all lanes
`default_nettype none
`include "dpt_consts.vh"
////////////////////////////////////////////////////////////////////////
module dpt_cfg_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, resetn = 0, avs_read = 0, avs_write = 0, data_bit = 0;
  logic tx_start = 0, pkt_done = 0, sym_start = 0, eighth_tick = 0;
  logic [7:0] avs_address = 8'h0, q;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, dev_step_ff;
  logic [3:0] avs_byteenable = 4'hf, dev_mant_ff;
  logic avs_waitrequest, preamble_restart_ff, fsk_en_ff, msk_phase_active, msk_phase_neg;
  logic ask_en_ff;
  logic [1:0] radio_state_ff;
  logic [2:0] dev_exp_ff;
  int error_cnt = 0, num_checks = 0;
  dpt_cfg u_dut (.mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_start, .pkt_done, .sym_start,
    .eighth_tick, .data_bit, .radio_state_ff, .preamble_restart_ff, .fsk_en_ff, .dev_mant_ff,
    .dev_exp_ff, .dev_step_ff, .msk_phase_active, .msk_phase_neg, .ask_en_ff);
  initial forever #12.5ns mclk = ~mclk;
////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata[7:0];
    avs_write <= 0;
    avs_read <= 0;
    @(posedge mclk);
  endtask
  // one-cycle start or end-of-packet pulse; results seen after return
  task tx(input logic done);
    tx_start <= !done;
    pkt_done <= done;
    @(posedge mclk);
    tx_start <= 0;
    pkt_done <= 0;
    @(posedge mclk);
  endtask
////////////////////////////////////////////////////////////////////////
  task s_regs;
    bus(0, `DPT_IDX_DEV, 8'h0);
    chk(q, 8'h47);
    bus(0, `DPT_IDX_SM1, 8'h0);
    chk(q, 8'h30);
    bus(0, `DPT_IDX_MOD, 8'h0);
    chk(q, 8'h0);
    bus(1, 8'h30, 8'hff);
    bus(0, 8'h30, 8'h0);
    chk(q, 8'h0);
    bus(1, `DPT_IDX_DEV, 8'hff);
    bus(0, `DPT_IDX_DEV, 8'h0);
    chk(q, 8'h77);
    bus(1, `DPT_IDX_SM1, 8'hc0);
    bus(0, `DPT_IDX_SM1, 8'h0);
    chk(q, 8'h30);
  endtask
  task s_mod;
    logic [2:0] mods [4] = '{3'h3, 3'h2, 3'h0, 3'h1};
    logic [2:0] e, m;
    for (int i = 0; i < 4; i++)
    begin
      e = 3'(i * 2 + 1);
      m = 3'(6 - i);
      bus(1, `DPT_IDX_MOD, {1'b0, mods[i], 4'h0});
      bus(1, `DPT_IDX_DEV, {1'b0, e, 1'b0, m});
      tx(0);
      chk(fsk_en_ff, mods[i] < 2);
      chk(ask_en_ff, mods[i] == 3);
      chk(dev_step_ff, mods[i] < 2 ? (8 + m) << e : 0);
      chk(dev_mant_ff, mods[i] < 2 ? {1'b1, m} : 0);
      chk(dev_exp_ff, mods[i] < 2 ? e : 0);
      tx(1);
    end
  endtask
  task s_post;
    for (int s = 0; s < 3; s++)
    begin
      bus(1, `DPT_IDX_SM1, 8'(s));
      tx(0);
      chk(radio_state_ff, `DPT_ST_TX);
      tx(1);
      chk(radio_state_ff, s == 2 ? `DPT_ST_TX : s);
      chk(preamble_restart_ff, s == 2);
    end
  endtask
  task s_msk;
    logic [31:0] n;
    logic dir;
    for (int b = 0; b < 2; b++)
    begin
      bus(1, `DPT_IDX_MOD, 8'h70);
      bus(1, `DPT_IDX_DEV, 8'h02);
      tx(0);
      data_bit <= b[0];
      sym_start <= 1;
      eighth_tick <= 1;
      @(posedge mclk);
      sym_start <= 0;
      n = 0;
      repeat (12)
      begin
        @(posedge mclk);
        n += msk_phase_active;
        if (msk_phase_active === 1'b1)
          dir = msk_phase_neg;
      end
      chk(n, 3);
      chk(dir, b[0]);
    end
  endtask
  task print_verdict;
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    s_regs;
    s_mod;
    s_post;
    s_msk;
    print_verdict;
  end
  // whole run is under 150 cycles; this leaves a wide margin
  initial
  begin
    #50us;
    error_cnt++;
    print_verdict;
  end
endmodule // dpt_cfg_test
`default_nettype wire
